// *** ixe_exec.sv ***
// execution slice for increment-skip-if-zero, or-literal and or-with-file
// assumes fetch holds the instruction word through Q1 and the file read
// port answers combinationally to file_addr_o while file_re_o is high
//
// Function
// - increment_skip_if_zero adds one to the file register and sends it to the accumulator (d=0) or back to the file (d=1).
// - a zero result makes the next instruction a no-operation so the instruction takes two cycles; nonzero takes one.
// - the phases are decode Q1, file read Q2, compute Q3, write Q4, and the skipped cycle does nothing in all four.
// - or_literal_into_accumulator ORs the 8-bit literal into the accumulator.
// - or_literal_into_accumulator finishes in one cycle: decode, take literal, compute, write accumulator.
`timescale 1ns/1ps
`default_nettype none
module ixe_exec
  import ixe_pkg::*;
(
  input wire logic clk_i, // core clock, 50 MHz
  input wire logic resetn_i, // async reset, active low
  input wire logic [ixe_pkg::INSTR_W-1:0] instr_i, // fetched word, valid in Q1
  input wire logic [ixe_pkg::DATA_W-1:0] file_rdata_i, // file read data
  output logic [ixe_pkg::FADDR_W-1:0] file_addr_o, // file address
  output logic file_re_o, // file read strobe, Q2
  output logic file_we_o, // file write strobe, Q4
  output logic [ixe_pkg::DATA_W-1:0] file_wdata_o, // file write data
  output logic [ixe_pkg::DATA_W-1:0] acc_o, // working accumulator
  output logic zero_o, // zero flag
  output logic zero_upd_o, // zero flag updated, pulse
  output logic skip_o // discard current instruction cycle
);
  import ixe_pkg::*;

  // ==========================================================
  // decode
  function automatic ixe_op_t ixe_decode(input logic [INSTR_W-1:0] w);
    ixe_op_t op;
    op = OP_NONE;
    if (w[OPC_MSB:OPC_LSB] == OPC_INC_SKIP)
    begin
      op = OP_INC_SKIP;
    end
    else if (w[OPC_MSB:OPC_LSB] == OPC_OR_LIT)
    begin
      op = OP_OR_LIT;
    end
    else if (w[OPC_MSB:OPC_LSB] == OPC_OR_FILE)
    begin
      op = OP_OR_FILE;
    end
    return op;
  endfunction : ixe_decode

  // ==========================================================
  // phase source
  logic [PHASE_W-1:0] phase;

  ixe_qphase u_qphase (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .phase_o(phase)
  );

  // ==========================================================
  // state
  ixe_state_t st_r;
  ixe_state_t st_nxt;
  logic to_acc;

  assign to_acc = (st_r.op == OP_OR_LIT) || (st_r.dest == DEST_ACC);

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.zero_upd = 1'b0;
    unique case (phase)
      PH_Q1:
      begin
        // skipped cycle decodes as no-operation
        st_nxt.op = st_r.skip ? OP_NONE : ixe_decode(instr_i);
        if (!st_r.skip)
        begin
          // discarded word leaves the operand fields alone
          st_nxt.dest = instr_i[DEST_BIT];
          st_nxt.lit = instr_i[LIT_MSB:0];
          st_nxt.file_addr = instr_i[FADDR_MSB:0];
        end
        st_nxt.file_re = (st_nxt.op == OP_INC_SKIP) || (st_nxt.op == OP_OR_FILE);
      end
      PH_Q2:
      begin
        st_nxt.opnd = (st_r.op == OP_OR_LIT) ? st_r.lit : file_rdata_i;
        st_nxt.file_re = 1'b0;
      end
      PH_Q3:
      begin
        unique case (st_r.op)
          OP_INC_SKIP: st_nxt.res = st_r.opnd + DATA_W'(1);
          OP_OR_LIT: st_nxt.res = st_r.acc | st_r.opnd;
          OP_OR_FILE: st_nxt.res = st_r.acc | st_r.opnd;
          OP_NONE: st_nxt.res = st_r.res;
        endcase
        st_nxt.file_we = (st_r.op != OP_NONE) && !to_acc;
        st_nxt.file_wdata = st_nxt.res;
      end
      PH_Q4:
      begin
        st_nxt.file_we = 1'b0;
        if ((st_r.op != OP_NONE) && to_acc)
        begin
          st_nxt.acc = st_r.res;
        end
        if ((st_r.op == OP_OR_LIT) || (st_r.op == OP_OR_FILE))
        begin
          st_nxt.zero = (st_r.res == '0);
          st_nxt.zero_upd = 1'b1;
        end
        // flush the prefetched word on a zero increment
        st_nxt.skip = (st_r.op == OP_INC_SKIP) && (st_r.res == '0);
        st_nxt.op = OP_NONE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st_r <= '{op: OP_NONE, dest: DEST_ACC, lit: '0, opnd: '0, res: '0,
                acc: ACC_RESET, zero: ZERO_RESET, zero_upd: 1'b0, skip: 1'b0,
                file_addr: '0, file_re: 1'b0, file_we: 1'b0, file_wdata: '0};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign file_addr_o = st_r.file_addr;
  assign file_re_o = st_r.file_re;
  assign file_we_o = st_r.file_we;
  assign file_wdata_o = st_r.file_wdata;
  assign acc_o = st_r.acc;
  assign zero_o = st_r.zero;
  assign zero_upd_o = st_r.zero_upd;
  assign skip_o = st_r.skip;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  sequence inc_q3_to_file;
    (phase == PH_Q3) && (st_r.op == OP_INC_SKIP) && (st_r.dest == DEST_FILE);
  endsequence

  sequence inc_q4_zero;
    (phase == PH_Q4) && (st_r.op == OP_INC_SKIP) && (st_r.res == '0);
  endsequence

  sequence or_lit_decoded;
    (phase == PH_Q1) && !skip_o && (ixe_decode(instr_i) == OP_OR_LIT);
  endsequence

  inc_write_file_a : assert property (
    inc_q3_to_file |=> file_we_o && (file_wdata_o == $past(st_r.opnd) + DATA_W'(1)))
    else $error("increment not written back to file");

  skip_on_zero_a : assert property (
    inc_q4_zero |=> skip_o [*4] ##1 !skip_o)
    else $error("zero increment did not skip exactly one cycle");

  no_skip_nonzero_a : assert property (
    (phase == PH_Q4) && (st_r.op == OP_INC_SKIP) && (st_r.res != '0) |=> !skip_o)
    else $error("skip raised on nonzero increment");

  strobe_phases_a : assert property (
    (file_re_o |-> phase == PH_Q2) and (file_we_o |-> phase == PH_Q4))
    else $error("file strobe outside its phase");

  skip_cycle_idle_a : assert property (
    skip_o |-> (!file_re_o && !file_we_o && !zero_upd_o && $stable(file_addr_o))
    ##1 ($stable(acc_o) && $stable(zero_o)))
    else $error("activity during skipped cycle");

  or_lit_result_a : assert property (
    (phase == PH_Q4) && (st_r.op == OP_OR_LIT)
    |=> acc_o == ($past(acc_o) | $past(st_r.lit)))
    else $error("literal or result wrong");

  or_lit_one_cycle_a : assert property (
    or_lit_decoded |-> ##4 (acc_o == ($past(acc_o, 4) | $past(instr_i[LIT_MSB:0], 4)))
    && zero_upd_o)
    else $error("literal or not done in one cycle");

  or_file_acc_a : assert property (
    (phase == PH_Q4) && (st_r.op == OP_OR_FILE) && (st_r.dest == DEST_ACC)
    |=> (acc_o == ($past(acc_o) | $past(st_r.opnd))) && (zero_o == (acc_o == '0)))
    else $error("file or to accumulator wrong");

  sequence file_op_decoded;
    (phase == PH_Q1) && !skip_o
    && ((ixe_decode(instr_i) == OP_INC_SKIP) || (ixe_decode(instr_i) == OP_OR_FILE));
  endsequence

  sequence or_file_q3_to_file;
    (phase == PH_Q3) && (st_r.op == OP_OR_FILE) && (st_r.dest == DEST_FILE);
  endsequence

  file_read_phase_a : assert property (
    file_op_decoded
    |=> (file_re_o && (file_addr_o == $past(instr_i[FADDR_MSB:0]))) ##1 !file_re_o)
    else $error("file read not issued in the read phase");

  inc_to_acc_a : assert property (
    (phase == PH_Q4) && (st_r.op == OP_INC_SKIP) && (st_r.dest == DEST_ACC)
    |=> acc_o == ($past(st_r.opnd) + DATA_W'(1)))
    else $error("increment not written to accumulator");

  inc_zero_keep_a : assert property (
    (phase == PH_Q4) && (st_r.op == OP_INC_SKIP) |=> $stable(zero_o) && !zero_upd_o)
    else $error("increment touched the zero flag");

  or_lit_zero_a : assert property (
    (phase == PH_Q4) && (st_r.op == OP_OR_LIT) |=> (zero_o == (acc_o == '0)) && zero_upd_o)
    else $error("literal or zero flag wrong");

  or_file_write_a : assert property (
    or_file_q3_to_file
    |=> (file_we_o && (file_wdata_o == ($past(acc_o) | $past(st_r.opnd))))
    ##1 ($stable(acc_o) && zero_upd_o && (zero_o == ($past(file_wdata_o) == '0))))
    else $error("file or to file wrong");

endmodule : ixe_exec
`default_nettype wire

// *** ixe_pkg.sv ***
// constants and types for the increment-skip / inclusive-or execution slice
// assumes a 14-bit instruction word and an 8-bit data path on one core clock
package ixe_pkg;

  // ==========================================================
  // widths
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned PHASE_W = 2;

  // ==========================================================
  // instruction word fields
  localparam int unsigned OPC_MSB = 13;
  localparam int unsigned OPC_LSB = 8;
  localparam int unsigned DEST_BIT = 7;
  localparam int unsigned FADDR_MSB = 6;
  localparam int unsigned LIT_MSB = 7;
  localparam logic [5:0] OPC_INC_SKIP = 6'h0F;
  localparam logic [5:0] OPC_OR_LIT = 6'h38;
  localparam logic [5:0] OPC_OR_FILE = 6'h04;
  localparam logic DEST_ACC = 1'h0;
  localparam logic DEST_FILE = 1'h1;

  // ==========================================================
  // timing: one quarter phase per core clock
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned TCY_NS = 80;
  localparam int unsigned Q_PHASES = TCY_NS / CLK_PERIOD_NS;
  localparam logic [PHASE_W-1:0] PH_Q1 = 2'h0;
  localparam logic [PHASE_W-1:0] PH_Q2 = 2'h1;
  localparam logic [PHASE_W-1:0] PH_Q3 = 2'h2;
  localparam logic [PHASE_W-1:0] PH_Q4 = 2'h3;
  localparam logic [PHASE_W-1:0] PH_LAST = PHASE_W'(Q_PHASES - 1);

  // ==========================================================
  // reset values
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic ZERO_RESET = 1'h0;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_INC_SKIP,
    OP_OR_LIT,
    OP_OR_FILE
  } ixe_op_t;

  typedef struct packed {
    ixe_op_t op;
    logic dest;
    logic [DATA_W-1:0] lit;
    logic [DATA_W-1:0] opnd;
    logic [DATA_W-1:0] res;
    logic [DATA_W-1:0] acc;
    logic zero;
    logic zero_upd;
    logic skip;
    logic [FADDR_W-1:0] file_addr;
    logic file_re;
    logic file_we;
    logic [DATA_W-1:0] file_wdata;
  } ixe_state_t;

endpackage : ixe_pkg

// *** ixe_qphase.sv ***
// quarter-phase sequencer: Q1..Q4 of each instruction cycle
// assumes one quarter phase per rising core clock edge
`timescale 1ns/1ps
`default_nettype none
module ixe_qphase
  import ixe_pkg::*;
(
  input wire logic clk_i, // core clock
  input wire logic resetn_i, // async reset, active low
  output logic [ixe_pkg::PHASE_W-1:0] phase_o // current quarter phase
);

  // ==========================================================
  // phase counter
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      phase_o <= PH_Q1;
    end
    else if (phase_o == PH_LAST)
    begin
      phase_o <= PH_Q1;
    end
    else
    begin
      phase_o <= phase_o + PHASE_W'(1);
    end
  end

endmodule : ixe_qphase
`default_nettype wire

// *** ixe_exec_tb.sv ***
// self-checking bench for ixe_exec: corner cases, a mid-run reset, random words
// assumes the bench acts as the file store behind the combinational read port
`timescale 1ns/1ps
`default_nettype none
module ixe_exec_tb;
  import ixe_pkg::*;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [INSTR_W-1:0] instr_i = '0;
  wire logic [DATA_W-1:0] file_rdata_i;
  logic [FADDR_W-1:0] file_addr_o;
  logic [DATA_W-1:0] file_wdata_o, acc_o, exp_acc;
  logic file_re_o, file_we_o, zero_o, zero_upd_o, skip_o, exp_zero;
  logic [DATA_W-1:0] mem [128];
  logic [DATA_W-1:0] exp_mem [128];
  logic [31:0] lfsr = 32'hA105;
  int n_errors = 0;
  int n_compared = 0;
  localparam logic [INSTR_W-1:0] CORNER [8] = '{
    {OPC_OR_LIT, 8'h00}, {OPC_OR_LIT, 8'h9A}, {OPC_OR_LIT, 8'h35},
    {OPC_INC_SKIP, DEST_FILE, 7'h05}, {OPC_INC_SKIP, DEST_ACC, 7'h06},
    {OPC_OR_FILE, DEST_FILE, 7'h07}, {OPC_INC_SKIP, DEST_ACC, 7'h05},
    {OPC_OR_FILE, DEST_ACC, 7'h08}};

  // ==========================================================
  // clock, file store, design
  always #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;
  // released read port shows inverted data
  assign file_rdata_i = file_re_o ? mem[file_addr_o] : ~mem[file_addr_o];
  always @(posedge clk_i)
    if (file_we_o) mem[file_addr_o] <= file_wdata_o;

  ixe_exec i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .instr_i(instr_i),
    .file_rdata_i(file_rdata_i), .file_addr_o(file_addr_o), .file_re_o(file_re_o),
    .file_we_o(file_we_o), .file_wdata_o(file_wdata_o), .acc_o(acc_o),
    .zero_o(zero_o), .zero_upd_o(zero_upd_o), .skip_o(skip_o));

  // ==========================================================
  // helpers
  function automatic logic [31:0] next_lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_lfsr

  // result of one word from accumulator and file operand
  function automatic logic [7:0] expect_result(input logic [INSTR_W-1:0] w,
      input logic [7:0] acc, input logic [7:0] fv);
    logic [5:0] opc;
    opc = w[OPC_MSB:OPC_LSB];
    if (opc == OPC_OR_LIT)
      return acc | w[LIT_MSB:0];
    else if (opc == OPC_OR_FILE)
      return acc | fv;
    return fv + 8'h01;
  endfunction : expect_result

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // one instruction cycle, two on a skip, entered just after a falling edge in Q1
  task automatic run(input logic [INSTR_W-1:0] w);
    logic [5:0] opc;
    logic [FADDR_W-1:0] f;
    logic [DATA_W-1:0] r;
    logic rd, wr, upd, skp;
    opc = w[OPC_MSB:OPC_LSB];
    f = w[FADDR_MSB:0];
    rd = opc == OPC_INC_SKIP || opc == OPC_OR_FILE;
    upd = opc == OPC_OR_LIT || opc == OPC_OR_FILE;
    wr = rd && w[DEST_BIT] == DEST_FILE;
    r = expect_result(w, exp_acc, exp_mem[f]);
    skp = opc == OPC_INC_SKIP && r == 8'h00;
    instr_i = w;
    @(negedge clk_i);
    instr_i = ~w;
    check(8'(file_re_o), 8'(rd), "read strobe");
    check(8'(zero_upd_o), 8'h00, "zero pulse early");
    if (rd) check(8'(file_addr_o), 8'(f), "file address");
    repeat (2) @(negedge clk_i);
    check(8'(file_we_o), 8'(wr), "write strobe");
    if (wr) check(file_wdata_o, r, "write data");
    @(negedge clk_i);
    if (wr)
      exp_mem[f] = r;
    else if (rd || upd)
      exp_acc = r;
    if (upd)
      exp_zero = r == 8'h00;
    check(acc_o, exp_acc, "accumulator");
    check(8'(zero_o), 8'(exp_zero), "zero flag");
    check(8'(zero_upd_o), 8'(upd), "zero pulse");
    check(mem[f], exp_mem[f], "file contents");
    check(8'(skip_o), 8'(skp), "skip flag");
    if (skp)
    begin
      // a word that would change the accumulator if it ran
      instr_i = {OPC_OR_LIT, 8'hFF};
      repeat (3)
      begin
        @(negedge clk_i);
        check(8'({skip_o, file_re_o, file_we_o}), 8'h04, "discarded cycle");
        check(8'(file_addr_o), 8'(f), "address held in skip");
      end
      @(negedge clk_i);
      check(8'({skip_o, zero_upd_o}), 8'h00, "after skip");
      check(acc_o, exp_acc, "accumulator after skip");
    end
  endtask : run

  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    logic [5:0] opc;
    for (int i = 0; i < 128; i++)
    begin
      lfsr = next_lfsr(lfsr);
      mem[i] = lfsr[7:0];
    end
    mem[5] = 8'hFF;
    mem[6] = 8'hFF;
    mem[7] = 8'h00;
    for (int i = 0; i < 128; i++)
      exp_mem[i] = mem[i];
    repeat (2) @(negedge clk_i);
    resetn_i = 1'b1;
    exp_acc = ACC_RESET;
    exp_zero = ZERO_RESET;
    for (int i = 0; i < 8; i++)
      run(CORNER[i]);
    resetn_i = 1'b0;
    @(negedge clk_i);
    check(acc_o, ACC_RESET, "accumulator in reset");
    check(8'({zero_o, skip_o, file_we_o, file_re_o, zero_upd_o}), 8'h00, "flags in reset");
    resetn_i = 1'b1;
    exp_acc = ACC_RESET;
    exp_zero = ZERO_RESET;
    repeat (300)
    begin
      lfsr = next_lfsr(lfsr);
      opc = lfsr[9:8] == 2'h0 ? OPC_INC_SKIP : lfsr[9:8] == 2'h1 ? OPC_OR_LIT :
            lfsr[9:8] == 2'h2 ? OPC_OR_FILE : lfsr[15:10];
      run({opc, lfsr[7:0]});
    end
    report_and_stop();
  end

  initial
  begin
    #(CLK_PERIOD_NS * 5000);
    n_errors++;
    report_and_stop();
  end
endmodule : ixe_exec_tb
`default_nettype wire
